// ==== capture_channel_defines.vh ====
// Constants for the capture channel control block: register offsets,
// control field positions, reset values and stream codes.
// Included by bare name from every design file of the block except the synchroniser.
`ifndef CAPTURE_CHANNEL_DEFINES_VH
`define CAPTURE_CHANNEL_DEFINES_VH

// Register offsets on the 4-bit byte address port
`define OFS_CTRL 4'h0
`define OFS_IRQ_STATUS 4'h4
`define OFS_IRQ_MASK 4'h8

// Control register field positions
`define CTRL_EDGE_BIT 31
`define CTRL_NIP_BIT 10
`define CTRL_VANC_BIT 9
`define CTRL_HANC_BIT 8
`define CTRL_IRQSEL_HI 7
`define CTRL_IRQSEL_LO 6
`define CTRL_FID_BIT 5
`define CTRL_LAYOUT_BIT 4
`define CTRL_YCMUX_BIT 3
`define CTRL_MODE_HI 2
`define CTRL_MODE_LO 1
`define CTRL_EN_BIT 0

// Writable control bits and reset values
`define CTRL_WR_MASK 32'h8000_07DF
`define CTRL_RESET 32'h0000_0000
`define IRQ_RESET 2'h0

// Frame interrupt field select
`define IRQSEL_TOP 2'h0
`define IRQSEL_BOTTOM 2'h1
`define IRQSEL_BOTH 2'h2

// Interrupt status bits
`define STAT_FRAME_BIT 0
`define STAT_CODE_ERR_BIT 1

// Kind of word handed to memory
`define KIND_ACTIVE 2'h0
`define KIND_HANC 2'h1
`define KIND_VANC 2'h2

// Timing reference preamble bytes
`define PREAMBLE_ONES 8'hFF
`define PREAMBLE_ZERO 8'h00

`endif

// ==== capture_control_assertions.sv ====
// Concurrent checks on the capture channel control block ports.
// Assumes a single sys_clk domain; bound to the block after the module.
`timescale 1ns/10ps
`include "capture_channel_defines.vh"
module capture_control_checker (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Settings and stream
    input wire capture_clock_edge_select,
    input wire channel_one_on,
    input wire [1:0] capture_data_mode,
    input wire scan_progressive_select,
    input wire mem_wr_valid,
    input wire [1:0] mem_wr_kind,
    input wire mem_wr_subpic,
    input wire frame_irq_pulse,
    input wire irq
);
    // Shadows rebuilt from the bus alone, so no internal state is peeked
    logic [31:0] ctrl_sh;
    logic mask_sh;
    wire ctrl_wr = reg_wr && reg_addr == `OFS_CTRL;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_sh <= 32'h0000_0000;
            mask_sh <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                ctrl_sh <= reg_wdata;
            end
            if (reg_wr && reg_addr == `OFS_IRQ_MASK) begin
                mask_sh <= reg_wdata[0];
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_reserved_zero:
    assert property ($past(reg_rd) && $past(reg_addr) == `OFS_CTRL
        |-> (reg_rdata & 32'h7FFF_F800) == 32'h0000_0000) else $error("reserved bits set");
    a_edge_follows:
    assert property (ctrl_wr |=> capture_clock_edge_select == $past(reg_wdata[31]))
        else $error("edge select pin wrong");
    a_mode_follows:
    assert property (ctrl_wr |=> capture_data_mode == $past(reg_wdata[2:1])
        && channel_one_on == $past(reg_wdata[0])) else $error("mode or enable pin wrong");
    a_scan_follows:
    assert property (ctrl_wr |=> scan_progressive_select == $past(reg_wdata[10]))
        else $error("scan select pin wrong");
    a_hanc_gate:
    assert property (mem_wr_valid && mem_wr_kind == `KIND_HANC |-> ctrl_sh[8])
        else $error("horizontal word stored while disabled");
    a_vanc_gate:
    assert property (mem_wr_valid && mem_wr_kind == `KIND_VANC |-> ctrl_sh[9])
        else $error("vertical word stored while disabled");
    a_anc_raster:
    assert property (mem_wr_valid && mem_wr_kind != `KIND_ACTIVE |-> !mem_wr_subpic)
        else $error("ancillary word not raster");
    a_sel_reserved:
    assert property (ctrl_sh[7:6] == 2'h3 |-> !frame_irq_pulse)
        else $error("interrupt with reserved select");
    a_pulse_single:
    assert property (frame_irq_pulse |=> !frame_irq_pulse [*3])
        else $error("frame pulse too long");
    a_irq_masked:
    assert property (frame_irq_pulse && mask_sh |-> irq) else $error("unmasked irq low");
    a_off_quiet:
    assert property (!channel_one_on && !$past(channel_one_on)
        |-> !mem_wr_valid && !frame_irq_pulse) else $error("activity while off");
endmodule // capture_control_checker

bind video_capture_channel_control capture_control_checker chk_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_clock_edge_select(capture_clock_edge_select),
    .channel_one_on(channel_one_on), .capture_data_mode(capture_data_mode),
    .scan_progressive_select(scan_progressive_select), .mem_wr_valid(mem_wr_valid),
    .mem_wr_kind(mem_wr_kind), .mem_wr_subpic(mem_wr_subpic),
    .frame_irq_pulse(frame_irq_pulse), .irq(irq));

// ==== sync_bits.v ====
// Two-flop synchroniser for a group of pin levels.
// Assumes each bit is a slow level or a clock far below sys_clk.
`timescale 1ns/10ps
module sync_bits #(
    parameter W = 12
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Levels
    input wire [W-1:0] pin_in,
    output reg [W-1:0] pin_out
);
    reg [W-1:0] meta_reg;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            pin_out <= {W{1'b0}};
        end else begin
            meta_reg <= pin_in;
            pin_out <= meta_reg;
        end
    end
endmodule // sync_bits

// ==== timing_code_decoder.v ====
// Finds embedded timing reference codes in a byte stream and passes
// the other bytes on three byte strobes late, with the preamble removed.
// Assumes byte_stb is a one-cycle pulse per incoming byte.
`timescale 1ns/10ps
`include "capture_channel_defines.vh"
module timing_code_decoder (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Incoming bytes
    input wire byte_stb,
    input wire [7:0] byte_in,
    // Timing code found
    output reg code_stb,
    output reg code_f,
    output reg code_v,
    output reg code_h,
    output reg code_err,
    // Bytes that are not part of a timing code
    output reg out_stb,
    output reg [7:0] out_byte
);
    reg [1:0] stage_reg;
    reg [23:0] hold_reg;
    reg [2:0] hold_vld_reg;
    wire code_now;

    assign code_now = byte_stb && (stage_reg == 2'h3);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg <= 2'h0;
            hold_reg <= 24'h00_0000;
            hold_vld_reg <= 3'h0;
            code_stb <= 1'b0;
            code_f <= 1'b0;
            code_v <= 1'b0;
            code_h <= 1'b0;
            code_err <= 1'b0;
            out_stb <= 1'b0;
            out_byte <= 8'h00;
        end else begin
            code_stb <= code_now;
            out_stb <= byte_stb && hold_vld_reg[2] && !code_now;
            if (byte_stb) begin
                out_byte <= hold_reg[23:16];
                hold_reg <= {hold_reg[15:0], byte_in};
                // Preamble bytes already held are dropped with the code
                hold_vld_reg <= code_now ? 3'h0 : {hold_vld_reg[1:0], 1'b1};
                if (code_now) begin
                    stage_reg <= 2'h0;
                    code_f <= byte_in[6];
                    code_v <= byte_in[5];
                    code_h <= byte_in[4];
                    // Protection bits must match F, V and H
                    code_err <= !byte_in[7] ||
                        (byte_in[3:0] != {byte_in[5] ^ byte_in[4], byte_in[6] ^ byte_in[4],
                         byte_in[6] ^ byte_in[5], byte_in[6] ^ byte_in[5] ^ byte_in[4]});
                end else if (byte_in == `PREAMBLE_ONES) begin
                    stage_reg <= 2'h1;
                end else if (byte_in == `PREAMBLE_ZERO && stage_reg != 2'h0) begin
                    stage_reg <= stage_reg + 2'h1;
                end else begin
                    stage_reg <= 2'h0;
                end
            end
        end
    end
endmodule // timing_code_decoder

// ==== video_capture_channel_control.v ====
// Control register of the second video capture channel, with the
// stream steering it governs: sync decode, ancillary word selection,
// frame interrupt and field identifier snapshot.
// Assumes the pixel clock is far below sys_clk, so it is sampled as a
// level; the clock edge inversion itself sits outside, at the pins.
//
// Behaviour
// R1: Bit 31 selects the data-change edge: 0 rising, 1 falling.
// R2: Edge select is only driven out; inversion happens outside at the pins.
// R3: Bit 10 selects scan format: 0 interlaced, 1 progressive.
// R4: Bit 9 set stores vertical blanking words between SAV and EAV; else drops.
// R5: Bit 8 set stores horizontal blanking words between EAV and SAV; else drops.
// R6: Bits 7-6 pick frame interrupt field: top, bottom, both, reserved.
// R7: Read-only field bit 5 updates on the frame interrupt pulse.
// R8: In raw sensor mode field bit 5 also follows the field pin level.
// R9: Bit 0 enables the channel: 0 off, 1 on.
// R10: Mode bits 2-1: 0-1 embedded sync, 2-3 raw; both channels alike.
// R11: Bit 4 picks luma layout raster or sub-picture; ancillary stays raster.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "capture_channel_defines.vh"
module video_capture_channel_control (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Video source pins
    input wire vid_clk,
    input wire [7:0] vid_data,
    input wire vid_field,
    input wire vid_hvalid,
    input wire vid_vvalid,
    // Settings driven to the pins and the other channel
    output wire capture_clock_edge_select,
    output wire channel_one_on,
    output wire [1:0] capture_data_mode,
    output wire luma_chroma_interleave,
    output wire scan_progressive_select,
    // Words handed to the memory writer
    output reg mem_wr_valid,
    output reg [7:0] mem_wr_data,
    output reg [1:0] mem_wr_kind,
    output reg mem_wr_subpic,
    // Interrupts
    output reg frame_irq_pulse,
    output wire irq
);
    // Control register fields
    reg edge_sel_reg;
    reg nip_reg;
    reg vanc_en_reg;
    reg hanc_en_reg;
    reg [1:0] irq_sel_reg;
    reg layout_reg;
    reg ycmux_reg;
    reg [1:0] mode_reg;
    reg enable_reg;
    reg fid_reg;
    reg fid_next;

    // Interrupt registers
    reg [1:0] irq_status_reg;
    reg [1:0] irq_status_next;
    reg [1:0] irq_mask_reg;

    // Synchronised pins
    wire [11:0] pins_s;
    wire vclk_s;
    wire field_s;
    wire hvalid_s;
    wire vvalid_s;
    wire [7:0] data_s;
    reg vclk_prev_reg;
    reg vvalid_prev_reg;
    wire byte_stb;

    // Embedded sync decode
    wire code_stb;
    wire code_f;
    wire code_v;
    wire code_h;
    wire code_err;
    wire emb_stb;
    wire [7:0] emb_byte;
    reg in_line_reg;
    reg vblank_reg;

    // Stream and event terms
    wire raw_mode;
    reg frame_start;
    reg frame_field;
    reg frame_fire;
    reg word_stb;
    reg [7:0] word_data;
    reg [1:0] word_kind;
    reg word_keep;
    wire [31:0] ctrl_value;

    function is_raw;
        input [1:0] mode;
        begin
            is_raw = mode[1];
        end
    endfunction

    // Whether a field of the given parity raises the frame interrupt
    function field_selected;
        input [1:0] sel;
        input bottom;
        begin
            case (sel)
                `IRQSEL_TOP: field_selected = !bottom;
                `IRQSEL_BOTTOM: field_selected = bottom;
                `IRQSEL_BOTH: field_selected = 1'b1;
                default: field_selected = 1'b0;
            endcase
        end
    endfunction

    // Pin synchronisers
    sync_bits #(
        .W(12)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in({vid_clk, vid_field, vid_hvalid, vid_vvalid, vid_data}),
        .pin_out(pins_s)
    );

    assign vclk_s = pins_s[11];
    assign field_s = pins_s[10];
    assign hvalid_s = pins_s[9];
    assign vvalid_s = pins_s[8];
    assign data_s = pins_s[7:0];

    // Data is always taken on the rising edge seen here; the pin logic
    // outside turns the clock round when the source launches on rising
    assign byte_stb = vclk_s && !vclk_prev_reg; // [R2]

    assign raw_mode = is_raw(mode_reg); // [R10]

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vclk_prev_reg <= 1'b0;
            vvalid_prev_reg <= 1'b0;
        end else begin
            vclk_prev_reg <= vclk_s;
            if (byte_stb) begin
                vvalid_prev_reg <= vvalid_s;
            end
        end
    end

    timing_code_decoder u_code_dec (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .byte_stb(byte_stb && !raw_mode),
        .byte_in(data_s),
        .code_stb(code_stb),
        .code_f(code_f),
        .code_v(code_v),
        .code_h(code_h),
        .code_err(code_err),
        .out_stb(emb_stb),
        .out_byte(emb_byte)
    );

    // Line region from the last timing code: SAV opens the line, EAV closes
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_line_reg <= 1'b0;
            vblank_reg <= 1'b0;
        end else if (code_stb) begin
            in_line_reg <= !code_h;
            vblank_reg <= code_v;
        end
    end

    // Start of vertical sync, per mode, and the field it belongs to
    always @* begin
        frame_start = 1'b0;
        frame_field = 1'b0;
        if (raw_mode) begin
            frame_start = byte_stb && vvalid_prev_reg && !vvalid_s;
            frame_field = field_s;
        end else begin
            frame_start = code_stb && code_h && code_v && !vblank_reg;
            frame_field = code_f;
        end
        // A progressive frame counts as a top field
        if (nip_reg) begin
            frame_field = 1'b0; // [R3]
        end
        frame_fire = enable_reg && frame_start &&
            field_selected(irq_sel_reg, frame_field); // [R6] [R9]
    end

    // Word selection: active video always, ancillary per enable bits
    always @* begin
        word_stb = 1'b0;
        word_data = 8'h00;
        word_kind = `KIND_ACTIVE;
        word_keep = 1'b0;
        if (raw_mode) begin
            word_stb = byte_stb;
            word_data = data_s;
            word_keep = hvalid_s && vvalid_s;
        end else begin
            word_stb = emb_stb;
            word_data = emb_byte;
            if (!in_line_reg) begin
                word_kind = `KIND_HANC;
                word_keep = hanc_en_reg; // [R5]
            end else if (vblank_reg) begin
                word_kind = `KIND_VANC;
                word_keep = vanc_en_reg; // [R4]
            end else begin
                word_kind = `KIND_ACTIVE;
                word_keep = 1'b1;
            end
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_valid <= 1'b0;
            mem_wr_data <= 8'h00;
            mem_wr_kind <= `KIND_ACTIVE;
            mem_wr_subpic <= 1'b0;
            frame_irq_pulse <= 1'b0;
        end else begin
            mem_wr_valid <= enable_reg && word_stb && word_keep; // [R9]
            frame_irq_pulse <= frame_fire;
            if (word_stb) begin
                mem_wr_data <= word_data;
                mem_wr_kind <= word_kind;
                // Sub-picture only for embedded-sync luma; ancillary stays raster
                mem_wr_subpic <= layout_reg && !raw_mode &&
                    (word_kind == `KIND_ACTIVE); // [R11]
            end
        end
    end

    // Field snapshot: taken with the frame pulse, tracks the pin in raw mode
    always @* begin
        fid_next = fid_reg;
        if (frame_fire) begin
            fid_next = frame_field; // [R7]
        end
        if (raw_mode) begin
            fid_next = field_s; // [R8]
        end
    end

    // Control register
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_sel_reg <= 1'b0;
            nip_reg <= 1'b0;
            vanc_en_reg <= 1'b0;
            hanc_en_reg <= 1'b0;
            irq_sel_reg <= `IRQSEL_TOP;
            layout_reg <= 1'b0;
            ycmux_reg <= 1'b0;
            mode_reg <= 2'h0;
            enable_reg <= 1'b0;
            fid_reg <= 1'b0;
        end else begin
            fid_reg <= fid_next;
            if (reg_wr && reg_addr == `OFS_CTRL) begin
                edge_sel_reg <= reg_wdata[`CTRL_EDGE_BIT]; // [R1]
                nip_reg <= reg_wdata[`CTRL_NIP_BIT]; // [R3]
                vanc_en_reg <= reg_wdata[`CTRL_VANC_BIT];
                hanc_en_reg <= reg_wdata[`CTRL_HANC_BIT];
                irq_sel_reg <= reg_wdata[`CTRL_IRQSEL_HI:`CTRL_IRQSEL_LO]; // [R6]
                layout_reg <= reg_wdata[`CTRL_LAYOUT_BIT]; // [R11]
                ycmux_reg <= reg_wdata[`CTRL_YCMUX_BIT];
                mode_reg <= reg_wdata[`CTRL_MODE_HI:`CTRL_MODE_LO]; // [R10]
                enable_reg <= reg_wdata[`CTRL_EN_BIT]; // [R9]
            end
        end
    end

    // Interrupt status: a new event wins over a write-one clear
    always @* begin
        irq_status_next = irq_status_reg;
        if (reg_wr && reg_addr == `OFS_IRQ_STATUS) begin
            irq_status_next = irq_status_reg & ~reg_wdata[1:0];
        end
        if (frame_fire) begin
            irq_status_next[`STAT_FRAME_BIT] = 1'b1;
        end
        if (enable_reg && code_stb && code_err) begin
            irq_status_next[`STAT_CODE_ERR_BIT] = 1'b1;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg <= `IRQ_RESET;
            irq_mask_reg <= `IRQ_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
            if (reg_wr && reg_addr == `OFS_IRQ_MASK) begin
                irq_mask_reg <= reg_wdata[1:0];
            end
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // Reserved bits read as zero
    assign ctrl_value = {edge_sel_reg, 20'h0_0000, nip_reg, vanc_en_reg, hanc_en_reg,
        irq_sel_reg, fid_reg, layout_reg, ycmux_reg, mode_reg, enable_reg} & `CTRL_WR_MASK
        | ({31'h0000_0000, fid_reg} << `CTRL_FID_BIT);

    // Read data stands for the cycle after the strobe only
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_CTRL: reg_rdata <= ctrl_value;
                `OFS_IRQ_STATUS: reg_rdata <= {30'h0000_0000, irq_status_reg};
                `OFS_IRQ_MASK: reg_rdata <= {30'h0000_0000, irq_mask_reg};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Settings driven out unchanged
    assign capture_clock_edge_select = edge_sel_reg; // [R1] [R2]
    assign channel_one_on = enable_reg;
    assign capture_data_mode = mode_reg;
    assign luma_chroma_interleave = ycmux_reg;
    assign scan_progressive_select = nip_reg;
endmodule // video_capture_channel_control

// ==== video_capture_channel_control_tb.sv ====
// Self-checking bench for the capture channel control block.
// Drives the register port and a source model; checker is bound in.
`timescale 1ns/10ps
`include "capture_channel_defines.vh"
module video_capture_channel_control_tb;
    logic sys_clk;
    logic rst_n;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    wire [31:0] reg_rdata;
    wire vid_clk, vid_field, vid_hvalid, vid_vvalid, mem_wr_valid, mem_wr_subpic;
    wire [7:0] vid_data, mem_wr_data;
    wire [1:0] capture_data_mode, mem_wr_kind;
    wire capture_clock_edge_select, channel_one_on, luma_chroma_interleave;
    wire scan_progressive_select, frame_irq_pulse, irq;
    int error_cnt = 0;
    int compares = 0;
    int pulses = 0;
    logic [10:0] got_q[$];
    logic [10:0] exp_q[$];
    logic [31:0] ctl [7] = '{32'h0000_0111, 32'h0000_0241, 32'h0000_0383,
        32'h0000_00D1, 32'h0000_0441, 32'h0000_0401, 32'h0000_0380};
    logic [6:0] fld = 7'h3A;

    video_capture_channel_control dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vid_clk(vid_clk),
        .vid_data(vid_data), .vid_field(vid_field), .vid_hvalid(vid_hvalid),
        .vid_vvalid(vid_vvalid), .capture_clock_edge_select(capture_clock_edge_select),
        .channel_one_on(channel_one_on), .capture_data_mode(capture_data_mode),
        .luma_chroma_interleave(luma_chroma_interleave),
        .scan_progressive_select(scan_progressive_select), .mem_wr_valid(mem_wr_valid),
        .mem_wr_data(mem_wr_data), .mem_wr_kind(mem_wr_kind),
        .mem_wr_subpic(mem_wr_subpic), .frame_irq_pulse(frame_irq_pulse), .irq(irq));
    video_source_model src_u (
        .vid_clk(vid_clk), .vid_data(vid_data), .vid_field(vid_field),
        .vid_hvalid(vid_hvalid), .vid_vvalid(vid_vvalid));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (mem_wr_valid === 1'b1) begin
            got_q.push_back({mem_wr_kind, mem_wr_subpic, mem_wr_data});
        end
        if (frame_irq_pulse === 1'b1) begin
            pulses++;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // Off the edge, so the source model never moves on a sampling edge
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic code(input logic f, input logic v, input logic h);
        src_u.send(`PREAMBLE_ONES);
        src_u.send(`PREAMBLE_ZERO);
        src_u.send(`PREAMBLE_ZERO);
        src_u.send({1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h});
    endtask
    task automatic cmp_words;
        chk("word count", exp_q.size(), got_q.size());
        for (int k = 0; k < exp_q.size() && k < got_q.size(); k++) begin
            chk("word", {21'h00_0000, exp_q[k]}, {21'h00_0000, got_q[k]});
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge sys_clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] c;
        logic [31:0] d;
        logic f;
        logic fire;
        logic fid_e;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rst_n = 1'b0;
        fid_e = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(4'(i * 4), d);
            chk("reset value", 32'h0000_0000, d);
        end
        wr(`OFS_CTRL, 32'hFFFF_FFFF);
        wr(4'hC, 32'hFFFF_FFFF);
        rd(`OFS_CTRL, d);
        chk("ctrl ones", `CTRL_WR_MASK, d);
        chk("pins", 32'h0000_003F, {26'h000_0000, capture_clock_edge_select,
            scan_progressive_select, luma_chroma_interleave, capture_data_mode,
            channel_one_on});
        rd(4'hC, d);
        chk("unmapped", 32'h0000_0000, d);
        for (int i = 0; i < 7; i++) begin
            c = ctl[i];
            f = fld[i];
            wr(`OFS_CTRL, c);
            wr(`OFS_IRQ_MASK, {31'h0000_0000, ~i[0]});
            got_q.delete();
            exp_q.delete();
            pulses = 0;
            // Progressive frames count as top fields
            fire = c[0] && c[7:6] != 2'h3
                && (c[7:6] == 2'h2 || c[7:6] == {1'b0, f & ~c[10]});
            if (fire) begin
                fid_e = f & ~c[10];
            end
            if (c[0]) begin
                exp_q.push_back({`KIND_ACTIVE, c[4] & ~c[2], 8'h10});
                if (c[8]) begin
                    exp_q.push_back({`KIND_HANC, 1'b0, 8'h20});
                    exp_q.push_back({`KIND_HANC, 1'b0, 8'h30});
                end
                if (c[9]) begin
                    exp_q.push_back({`KIND_VANC, 1'b0, 8'h40});
                end
            end
            code(f, 1'b0, 1'b0);
            src_u.send(8'h10);
            code(f, 1'b0, 1'b1);
            src_u.send(8'h20);
            code(f, 1'b1, 1'b1);
            src_u.send(8'h30);
            code(f, 1'b1, 1'b0);
            src_u.send(8'h40);
            code(f, 1'b1, 1'b1);
            repeat (8) @(posedge sys_clk);
            cmp_words();
            chk("pulses", {31'h0000_0000, fire}, pulses);
            chk("irq", {31'h0000_0000, fire & ~i[0]}, {31'h0000_0000, irq});
            rd(`OFS_CTRL, d);
            chk("ctrl fid", c | {26'h000_0000, fid_e, 5'h00}, d);
            rd(`OFS_IRQ_STATUS, d);
            chk("status", {31'h0000_0000, fire}, d);
            wr(`OFS_IRQ_STATUS, 32'h0000_0003);
            rd(`OFS_IRQ_STATUS, d);
            chk("status clear", 32'h0000_0000, d);
            chk("irq clear", 32'h0000_0000, {31'h0000_0000, irq});
        end
        // A timing code with broken protection bits raises the error event
        wr(`OFS_CTRL, 32'h0000_0001);
        for (int k = 0; k < 4; k++) begin
            src_u.send(k == 0 ? `PREAMBLE_ONES : k == 3 ? 8'h81 : `PREAMBLE_ZERO);
        end
        repeat (4) @(posedge sys_clk);
        rd(`OFS_IRQ_STATUS, d);
        chk("code error", 32'h0000_0002, d);
        wr(`OFS_CTRL, 32'h0000_0005);
        for (int j = 0; j < 2; j++) begin
            f = !j[0];
            src_u.sync(f, j[0], j[0]);
            repeat (4) @(posedge sys_clk);
            rd(`OFS_CTRL, d);
            chk("raw fid", {26'h000_0000, f, 5'h05}, d);
        end
        wr(`OFS_CTRL, 32'h0000_0007);
        got_q.delete();
        exp_q = '{{`KIND_ACTIVE, 1'b0, 8'h5A}};
        pulses = 0;
        src_u.send(8'h5A);
        src_u.sync(1'b0, 1'b0, 1'b0);
        src_u.send(8'hA5);
        repeat (8) @(posedge sys_clk);
        cmp_words();
        chk("raw pulse", 32'h0000_0001, pulses);
        tally_and_finish();
    end
endmodule // video_capture_channel_control_tb

// ==== video_source_model.sv ====
// Video source model: byte stream with its own 800 ns pixel clock.
// The pixel clock rests low between bytes; sync levels set by task.
`timescale 1ns/10ps
module video_source_model (
    // Pixel clock and data
    output logic vid_clk,
    output logic [7:0] vid_data,
    // Raw mode sync levels
    output logic vid_field,
    output logic vid_hvalid,
    output logic vid_vvalid
);
    initial begin
        vid_clk = 1'b0;
        vid_data = 8'h00;
        vid_field = 1'b0;
        vid_hvalid = 1'b0;
        vid_vvalid = 1'b0;
    end
    // Data launched before the rising edge; edge inversion is not ours
    task automatic send(input logic [7:0] b);
        vid_data = b;
        #400;
        vid_clk = 1'b1;
        #400;
        vid_clk = 1'b0;
        // Hold time over: a late sample must not see the old byte
        vid_data = ~b;
    endtask
    task automatic sync(input logic f, input logic h, input logic v);
        vid_field = f;
        vid_hvalid = h;
        vid_vvalid = v;
    endtask
endmodule // video_source_model
